// ---- core/gdp_top.sv ----
// interlock, gate monitor, mode sequencing and self-test of the gate driver
// assumes an AXI4-Lite master on SYS_CLK and asynchronous analog/pin inputs
`timescale 1ns/1ns
module gdp_top import gdp_pkg::*; #(
	parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic PWM_COMMAND_IN,
	input wire logic COUNTERPART_PWM_IN,
	input wire logic GATE_LEVEL_CMP_ONE,
	input wire logic GATE_LEVEL_CMP_TWO,
	input wire logic DESATURATION_CHECK,
	input wire logic SECONDARY_SUPPLY_LOCKOUT,
	input wire logic DIG_SUPPLY_VALID,
	output logic GATE_ON,
	output logic [1:0] TURN_ON_LEVEL_OUT,
	output logic FAULT_N,
	output logic SUPPLY_LOW_ALERT_N_O,
	output logic SUPPLY_LOW_ALERT_N_OE_N
);
	logic [6:0] sync_meta; // first stage, read only by sync_q
	logic [6:0] sync_q; // settled pin levels
	logic pwm_s, cp_s, gc1_s, gc2_s, desaturation_check_s, lockout_s, digok_s;
	logic aw_held, w_held; // captured write halves
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire, w_mapped, r_mapped;
	logic [31:0] rd_data;
	logic [7:0] cfg, prim_stc, sec_stc;
	gdp_mode_t mode, next_mode;
	logic cmd_bad, parity_ok, timeout_hit, in_test;
	logic [31:0] to_cnt; // time spent in test modes
	logic sel_desat1; // applied selection
	logic cp_prev;
	logic [$clog2(DEAD_CYC+1)-1:0] dead_cnt;
	logic [$clog2(POWERUP_CYC+1)-1:0] pu_cnt;
	logic [$clog2(FILTER_CYC+1)-1:0] filt_cnt;
	logic powerup, inhibit, violation, st_set, pwm_lock, pwm_ok;
	logic next_gate_on, desaturation_check_in, desaturation_check_set;
	logic [$clog2(BLANK_CYC+1)-1:0] blank_cnt;
	logic [2:0] err, err_set, err_clr, next_err;

	// byte-lane merge for writable registers
	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
		input logic lane);
		merge8 = lane ? nw : old;
	endfunction

	// two-flop synchroniser for every pin input
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync_meta <= 7'h00;
			sync_q <= 7'h00;
		end else begin
			sync_meta <= {DIG_SUPPLY_VALID, SECONDARY_SUPPLY_LOCKOUT, DESATURATION_CHECK,
				GATE_LEVEL_CMP_TWO, GATE_LEVEL_CMP_ONE, COUNTERPART_PWM_IN, PWM_COMMAND_IN};
			sync_q <= sync_meta;
		end
	end
	assign pwm_s = sync_q[0];
	assign cp_s = sync_q[1];
	assign gc1_s = sync_q[2];
	assign gc2_s = sync_q[3];
	assign desaturation_check_s = sync_q[4];
	assign lockout_s = sync_q[5];
	assign digok_s = sync_q[6];

	// write channel: address and data taken in either order
	assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
	assign wr_fire = aw_held && w_held;
	assign w_mapped = (aw_addr == OFS_CONFIG) || (aw_addr == OFS_MODE_CMD) ||
		(aw_addr == OFS_PRIM_STC) || (aw_addr == OFS_SEC_STC) || (aw_addr == OFS_ERRORS);
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (wr_fire) begin
				// status register is read-only, so it answers an error too
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= w_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// read mux; the timers and counters of the block are not visible
	always_comb begin
		rd_data = 32'h00000000;
		r_mapped = 1'b1;
		unique case (S_AXI_ARADDR)
			OFS_CONFIG: rd_data[7:0] = cfg;
			OFS_MODE_CMD: rd_data[4:0] = mode;
			OFS_PRIM_STC: rd_data[7:0] = prim_stc;
			OFS_SEC_STC: rd_data[7:0] = sec_stc;
			OFS_STATUS: begin
				rd_data[ST_INTERLOCK] = inhibit | pwm_lock;
				rd_data[ST_GC1] = gc1_s;
				rd_data[ST_GC2] = gc2_s;
				rd_data[ST_ALERT] = !SUPPLY_LOW_ALERT_N_OE_N;
				rd_data[ST_MODE_LSB +: 5] = mode;
				rd_data[ST_DESAT1_SEL] = sel_desat1;
			end
			OFS_ERRORS: rd_data[2:0] = err;
			default: r_mapped = 1'b0;
		endcase
	end

	// read channel, one read in flight
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_data;
			S_AXI_RRESP <= r_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// configuration: parity enable, booster compensation, soft turn-off value
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg <= CFG_RESET;
		end else if (wr_fire && aw_addr == OFS_CONFIG) begin
			cfg <= merge8(cfg, w_data[7:0], w_strb[0]) & CFG_MASK;
		end
	end

	// self-test fields accept writes only in configuration mode
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			prim_stc <= STC_RESET;
			sec_stc <= STC_RESET;
		end else if (wr_fire && mode == CONFIGURATION_MODE) begin
			if (aw_addr == OFS_PRIM_STC) begin
				prim_stc <= merge8(prim_stc, w_data[7:0], w_strb[0]);
			end
			if (aw_addr == OFS_SEC_STC) begin
				sec_stc <= merge8(sec_stc, w_data[7:0], w_strb[0]);
			end
		end
	end

	// mode sequencing; parity counts over the whole low half-word
	assign parity_ok = !cfg[CFG_PARITY_BIT] || (^w_data[15:0]);
	assign in_test = (mode == VERIFICATION_MODE) || (mode == PROBE_TURN_ON_MODE);
	assign timeout_hit = in_test && (to_cnt == TIMEOUT_CYCLES - 1);
	always_comb begin
		next_mode = mode;
		cmd_bad = 1'b0;
		if (timeout_hit) begin
			next_mode = INITIAL_MODE;
		end else if (wr_fire && aw_addr == OFS_MODE_CMD) begin
			if (!parity_ok) begin
				cmd_bad = 1'b1;
			end else if (w_data[3:0] == CMD_EXIT) begin
				next_mode = INITIAL_MODE;
			end else begin
				unique case (mode)
					INITIAL_MODE: begin
						if (w_data[3:0] == CMD_CONFIG) next_mode = CONFIGURATION_MODE;
						else cmd_bad = 1'b1;
					end
					CONFIGURATION_MODE: begin
						if (w_data[3:0] == CMD_ACTIVE) next_mode = ACTIVE_MODE;
						else if (w_data[3:0] == CMD_VERIFY) next_mode = VERIFICATION_MODE;
						else cmd_bad = 1'b1;
					end
					ACTIVE_MODE: cmd_bad = 1'b1;
					VERIFICATION_MODE: begin
						if (w_data[3:0] == CMD_PROBE) next_mode = PROBE_TURN_ON_MODE;
						else cmd_bad = 1'b1;
					end
					PROBE_TURN_ON_MODE: cmd_bad = 1'b1;
					default: next_mode = INITIAL_MODE; // corrupted state falls back safe
				endcase
			end
		end
	end

	// mode register
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) mode <= INITIAL_MODE;
		else mode <= next_mode;
	end

	// test-mode timer runs across verification and probe as one window
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) to_cnt <= 32'h00000000;
		else if (!in_test || timeout_hit) to_cnt <= 32'h00000000;
		else to_cnt <= to_cnt + 32'h00000001;
	end

	// selection is applied on entering verification, dropped on leaving tests
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) sel_desat1 <= 1'b0;
		else if (mode == CONFIGURATION_MODE && next_mode == VERIFICATION_MODE)
			sel_desat1 <= sec_stc[SEC_DESAT1_BIT];
		else if (next_mode != VERIFICATION_MODE && next_mode != PROBE_TURN_ON_MODE)
			sel_desat1 <= 1'b0;
	end

	// interlock timers: dead time after counterpart off, power-up window
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cp_prev <= 1'b0;
			dead_cnt <= '0;
			pu_cnt <= ($clog2(POWERUP_CYC+1))'(POWERUP_CYC);
		end else begin
			cp_prev <= cp_s;
			if (cp_prev && !cp_s) dead_cnt <= ($clog2(DEAD_CYC+1))'(DEAD_CYC);
			else if (dead_cnt != '0) dead_cnt <= dead_cnt - 1'b1;
			if (pu_cnt != '0) pu_cnt <= pu_cnt - 1'b1;
		end
	end
	assign powerup = (pu_cnt != '0);
	// no control bit exists to turn the interlock off
	assign inhibit = cp_s | cp_prev | (dead_cnt != '0) | powerup;
	assign violation = pwm_s & inhibit;
	assign st_set = violation && (filt_cnt == ($clog2(FILTER_CYC+1))'(FILTER_CYC - 1));
	assign pwm_ok = pwm_s & !inhibit & !pwm_lock;

	// glitch filter and lock of an ignored high level until it ends
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			filt_cnt <= '0;
			pwm_lock <= 1'b0;
		end else begin
			if (!violation) filt_cnt <= '0;
			else if (filt_cnt != ($clog2(FILTER_CYC+1))'(FILTER_CYC)) filt_cnt <= filt_cnt + 1'b1;
			if (!pwm_s) pwm_lock <= 1'b0;
			else if (violation) pwm_lock <= 1'b1;
		end
	end

	// output stage drives only in active or probe mode and with no desaturation_check fault
	assign next_gate_on = pwm_ok && (mode == ACTIVE_MODE || mode == PROBE_TURN_ON_MODE) &&
		!err[ERR_DESATURATION_CHECK];
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			GATE_ON <= 1'b0;
			TURN_ON_LEVEL_OUT <= 2'h0;
		end else begin
			GATE_ON <= next_gate_on;
			TURN_ON_LEVEL_OUT[TON_REDUCED_BIT] <= (next_mode == PROBE_TURN_ON_MODE);
			TURN_ON_LEVEL_OUT[TON_COMP_BIT] <= cfg[CFG_BOOST_BIT];
		end
	end

	// desaturation_check blanking: comparator ignored for the first cycles of each turn-on
	assign desaturation_check_in = desaturation_check_s | sel_desat1;
	assign desaturation_check_set = GATE_ON && (blank_cnt == '0) && desaturation_check_in;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) blank_cnt <= ($clog2(BLANK_CYC+1))'(BLANK_CYC);
		else if (!GATE_ON) blank_cnt <= ($clog2(BLANK_CYC+1))'(BLANK_CYC);
		else if (blank_cnt != '0) blank_cnt <= blank_cnt - 1'b1;
	end

	// sticky errors, write one to clear; a new event beats the clear
	always_comb begin
		err_set = 3'h0;
		err_set[ERR_ST] = st_set;
		err_set[ERR_SER] = cmd_bad | (wr_fire & !w_mapped);
		err_set[ERR_DESATURATION_CHECK] = desaturation_check_set;
		err_clr = (wr_fire && aw_addr == OFS_ERRORS && w_strb[0]) ? w_data[2:0] : 3'h0;
		next_err = err_set | (err & ~err_clr);
	end
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			err <= 3'h0;
			FAULT_N <= 1'b1;
		end else begin
			err <= next_err;
			FAULT_N <= !next_err[ERR_DESATURATION_CHECK];
		end
	end

	// open-drain alert; held low from reset until supplies read good
	assign SUPPLY_LOW_ALERT_N_O = 1'b0;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) SUPPLY_LOW_ALERT_N_OE_N <= 1'b0;
		else SUPPLY_LOW_ALERT_N_OE_N <= !(lockout_s || !digok_s);
	end

	// checks
	AST_COUNTERPART_BLOCKS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		cp_s |=> !GATE_ON) else $error("gate on while counterpart on");
	AST_VIOLATION_FLAGS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		violation [*7] |=> err[ERR_ST]) else $error("held violation not flagged");
	AST_GLITCH_FILTERED: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(err[ERR_ST]) |-> $past(violation) && $past(filt_cnt) == 3'h6)
		else $error("flag set by short glitch");
	AST_DEAD_TIME: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$fell(cp_s) |-> inhibit [*7]) else $error("dead time too short");
	AST_POWERUP_BLOCK: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		powerup |=> !GATE_ON) else $error("turn-on during power-up");
	AST_ALERT_FOLLOWS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(lockout_s || !digok_s) |=> !SUPPLY_LOW_ALERT_N_OE_N) else $error("alert not driven");
	AST_ACTIVE_REFUSE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		mode == ACTIVE_MODE |=> mode == ACTIVE_MODE || mode == INITIAL_MODE)
		else $error("test mode entered from active");
	AST_TIMEOUT_EXIT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		timeout_hit |=> mode == INITIAL_MODE) else $error("timeout did not exit");
	AST_PROBE_REDUCED: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(GATE_ON && mode == PROBE_TURN_ON_MODE && $stable(mode))
		|-> TURN_ON_LEVEL_OUT[TON_REDUCED_BIT]) else $error("probe not reduced");
	AST_DESATURATION_CHECK_AFTER_BLANK: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(GATE_ON && blank_cnt == '0 && sel_desat1) |=> err[ERR_DESATURATION_CHECK] && !FAULT_N)
		else $error("forced desaturation_check not raised");
	AST_SET_WINS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		err_set[ERR_SER] |=> err[ERR_SER]) else $error("serial error lost");
endmodule

// ---- inc/gdp_pkg.sv ----
// constants, register map and mode type of the gate driver protection block
// assumes one 125 MHz clock; all times below are turned into cycle counts here
package gdp_pkg;
	// clock and timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned FILTER_NS = 50;
	localparam int unsigned FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DEAD_NS = 50;
	localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned POWERUP_NS = 10000;
	localparam int unsigned POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BLANK_NS = 2000;
	localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TIMEOUT_NS = 1000000;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
	// register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_MODE_CMD = 8'h04;
	localparam logic [7:0] OFS_PRIM_STC = 8'h08;
	localparam logic [7:0] OFS_SEC_STC = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_ERRORS = 8'h14;
	// config fields
	localparam int unsigned CFG_PARITY_BIT = 0;
	localparam int unsigned CFG_BOOST_BIT = 1;
	localparam int unsigned CFG_STVAL_LSB = 4;
	localparam logic [7:0] CFG_MASK = 8'hF3;
	localparam logic [7:0] CFG_RESET = 8'h01;
	localparam logic [7:0] STC_RESET = 8'h00;
	localparam int unsigned SEC_DESAT1_BIT = 0;
	// status fields
	localparam int unsigned ST_INTERLOCK = 0;
	localparam int unsigned ST_GC1 = 1;
	localparam int unsigned ST_GC2 = 2;
	localparam int unsigned ST_ALERT = 3;
	localparam int unsigned ST_MODE_LSB = 4;
	localparam int unsigned ST_DESAT1_SEL = 16;
	// error flags
	localparam int unsigned ERR_ST = 0;
	localparam int unsigned ERR_SER = 1;
	localparam int unsigned ERR_DESATURATION_CHECK = 2;
	// mode commands, odd parity over bits 15:0
	localparam logic [3:0] CMD_EXIT = 4'h0;
	localparam logic [3:0] CMD_CONFIG = 4'h2;
	localparam logic [3:0] CMD_ACTIVE = 4'h3;
	localparam logic [3:0] CMD_VERIFY = 4'h5;
	localparam logic [3:0] CMD_PROBE = 4'h6;
	// turn-on level output fields
	localparam int unsigned TON_REDUCED_BIT = 0;
	localparam int unsigned TON_COMP_BIT = 1;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [4:0] {
		INITIAL_MODE = 5'h01,
		CONFIGURATION_MODE = 5'h02,
		ACTIVE_MODE = 5'h04,
		VERIFICATION_MODE = 5'h08,
		PROBE_TURN_ON_MODE = 5'h10
	} gdp_mode_t;
endpackage

// ---- verif/gdp_pwm_host.sv ----
// host model for the two pwm pins of the gate driver
// assumes requests come from the bench and change only just after SYS_CLK edges
`timescale 1ns/1ns
module gdp_pwm_host (
	input wire logic SYS_CLK,
	input wire logic own_req,
	input wire logic cp_req,
	output logic own_pwm,
	output logic cp_pwm
);
	// pins follow requests one edge later, like a timer output of the host
	always_ff @(posedge SYS_CLK) begin
		own_pwm <= own_req;
		cp_pwm <= cp_req;
	end
endmodule

// ---- verif/gdp_top_test.sv ----
// self-checking bench of the gate driver protection block
// assumes the pwm host model on the pins and an AXI4-Lite master in this file
`timescale 1ns/1ns
module gdp_top_test import gdp_pkg::*; ();
	localparam int unsigned TMO = 2000; // short test-mode timeout keeps the run brief
	logic clk = 1'h0, rst_n = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, seed = 32'hE1F3;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, gate_on, fault_n, al_o, al_oe_n;
	logic [1:0] bresp, rresp, turn_on_level_out;
	// pin and comparator stand-ins
	logic own_req = 1'h0, cp_req = 1'h0, own_pwm, cp_pwm;
	logic gc1 = 1'h0, gc2 = 1'h0, desaturation_check = 1'h0, lockout = 1'h0, dig_ok = 1'h1;
	// reference model state
	logic [4:0] mode_m = 5'h01;
	logic [2:0] err_m = 3'h0;
	logic [7:0] cfg_m = CFG_RESET;
	logic sel_m = 1'h0;
	int mismatches = 0, checked = 0;
	wire alert_wire = al_oe_n ? 1'h1 : al_o; // pulled up while released

	gdp_pwm_host gdp_pwm_host_i (.SYS_CLK(clk), .own_req(own_req), .cp_req(cp_req),
		.own_pwm(own_pwm), .cp_pwm(cp_pwm));
	gdp_top #(.TIMEOUT_CYCLES(TMO)) gdp_top_i (.SYS_CLK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PWM_COMMAND_IN(own_pwm),
		.COUNTERPART_PWM_IN(cp_pwm), .GATE_LEVEL_CMP_ONE(gc1), .GATE_LEVEL_CMP_TWO(gc2),
		.DESATURATION_CHECK(desaturation_check), .SECONDARY_SUPPLY_LOCKOUT(lockout),
		.DIG_SUPPLY_VALID(dig_ok), .GATE_ON(gate_on), .TURN_ON_LEVEL_OUT(turn_on_level_out),
		.FAULT_N(fault_n), .SUPPLY_LOW_ALERT_N_O(al_o), .SUPPLY_LOW_ALERT_N_OE_N(al_oe_n));

	// 125 MHz system clock
	always #4 clk = ~clk;

	// xorshift source for comparator levels
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one write; address and data released each at its own acceptance
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic aw_ok, w_ok;
		@(posedge clk);
		aw_ok = 1'h0;
		w_ok = 1'h0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (awvalid && awready === 1'h1) begin
				aw_ok = 1'h1;
				awvalid <= 1'h0;
			end
			if (wvalid && wready === 1'h1) begin
				w_ok = 1'h1;
				wvalid <= 1'h0;
			end
		end
		while (bvalid !== 1'h1) @(posedge clk);
		bready <= 1'h0;
		chk(32'(bresp), 32'(er));
	endtask

	// one read compared with the model value
	task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		@(posedge clk);
		while (arready !== 1'h1) @(posedge clk);
		arvalid <= 1'h0;
		@(posedge clk);
		while (rvalid !== 1'h1) @(posedge clk);
		rready <= 1'h0;
		chk(rdata, ed);
		chk(32'(rresp), 32'(er));
	endtask

	task automatic echk();
		rchk(OFS_ERRORS, 32'(err_m), RESP_OKAY);
	endtask

	task automatic eclr();
		wr(OFS_ERRORS, 32'h7, 4'hF, RESP_OKAY);
		err_m = 3'h0;
	endtask

	// status word built from the model and the driven pins
	task automatic schk(input logic ilk);
		rchk(OFS_STATUS, {15'h0, sel_m, 7'h0, mode_m, lockout | !dig_ok, gc2, gc1, ilk},
			RESP_OKAY);
	endtask

	// mode command with good or broken parity; model decides acceptance
	task automatic mcmd(input logic [3:0] c, input logic good);
		logic [4:0] nm;
		nm = 5'h00;
		if (c == CMD_EXIT) nm = 5'h01;
		if (c == CMD_CONFIG && mode_m == 5'h01) nm = 5'h02;
		if (c == CMD_ACTIVE && mode_m == 5'h02) nm = 5'h04;
		if (c == CMD_VERIFY && mode_m == 5'h02) nm = 5'h08;
		if (c == CMD_PROBE && mode_m == 5'h08) nm = 5'h10;
		wr(OFS_MODE_CMD, {16'h0, (~^c) ^ ~good, 11'h0, c}, 4'hF, RESP_OKAY);
		if (nm != 5'h00 && (good || !cfg_m[CFG_PARITY_BIT])) mode_m = nm;
		else err_m[ERR_SER] = 1'h1;
		rchk(OFS_MODE_CMD, 32'(mode_m), RESP_OKAY);
		echk();
	endtask

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		cyc(12);
		rst_n <= 1'h1;
		own_req <= 1'h1; // pwm active inside the power-up window
		cyc(20);
		chk(32'(gate_on), 32'h0);
		chk(32'(alert_wire), 32'h1);
		own_req <= 1'h0;
		err_m[ERR_ST] = 1'h1;
		cyc(4);
		echk();
		eclr();
		echk();
		rchk(OFS_CONFIG, 32'(CFG_RESET), RESP_OKAY);
		rchk(8'h18, 32'h0, RESP_SLVERR);
		cyc(POWERUP_CYC);
		mcmd(CMD_CONFIG, 1'h0);
		mcmd(CMD_ACTIVE, 1'h1);
		eclr();
		wr(OFS_STATUS, 32'h0, 4'hF, RESP_SLVERR);
		err_m[ERR_SER] = 1'h1;
		echk();
		eclr();
		mcmd(CMD_CONFIG, 1'h1);
		wr(OFS_CONFIG, 32'hF3, 4'h0, RESP_OKAY);
		rchk(OFS_CONFIG, 32'(cfg_m), RESP_OKAY);
		wr(OFS_CONFIG, 32'h02, 4'hF, RESP_OKAY);
		cfg_m = 8'h02; // parity off, booster compensation on
		// primary self-test field takes writes in configuration mode
		wr(OFS_PRIM_STC, 32'h04, 4'hF, RESP_OKAY);
		rchk(OFS_PRIM_STC, 32'h04, RESP_OKAY);
		wr(OFS_PRIM_STC, 32'h00, 4'hF, RESP_OKAY);
		mcmd(CMD_ACTIVE, 1'h0);
		// self-test fields ignore writes outside configuration mode
		wr(OFS_SEC_STC, 32'h1, 4'hF, RESP_OKAY);
		rchk(OFS_SEC_STC, 32'h0, RESP_OKAY);
		// normal turn-on, then counterpart takes over
		own_req <= 1'h1;
		cyc(6);
		chk(32'(gate_on), 32'h1);
		chk(32'(turn_on_level_out), 32'h2);
		cp_req <= 1'h1;
		cyc(5);
		chk(32'(gate_on), 32'h0);
		own_req <= 1'h0;
		cyc(4);
		own_req <= 1'h1; // 32 ns glitch while inhibited
		cyc(4);
		own_req <= 1'h0;
		cyc(6);
		echk();
		own_req <= 1'h1;
		cyc(20);
		chk(32'(gate_on), 32'h0);
		err_m[ERR_ST] = 1'h1;
		schk(1'h1);
		echk();
		own_req <= 1'h0;
		cp_req <= 1'h0;
		cyc(12);
		eclr();
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			gc1 <= seed[0];
			gc2 <= seed[1];
			cyc(4);
			schk(1'h0);
		end
		mcmd(CMD_VERIFY, 1'h1);
		eclr();
		mcmd(CMD_EXIT, 1'h1);
		mcmd(4'h9, 1'h1);
		eclr();
		mcmd(CMD_CONFIG, 1'h1);
		wr(OFS_SEC_STC, 32'h1, 4'hF, RESP_OKAY);
		schk(1'h0);
		mcmd(CMD_VERIFY, 1'h1);
		sel_m = 1'h1;
		schk(1'h0);
		mcmd(CMD_PROBE, 1'h1);
		own_req <= 1'h1;
		cyc(6);
		chk(32'(gate_on), 32'h1);
		chk(32'(turn_on_level_out), 32'h3);
		cyc(BLANK_CYC - 10);
		chk(32'(fault_n), 32'h1);
		cyc(12);
		chk(32'(fault_n), 32'h0);
		chk(32'(gate_on), 32'h0);
		own_req <= 1'h0;
		err_m[ERR_DESATURATION_CHECK] = 1'h1;
		echk();
		cyc(TMO);
		mode_m = 5'h01;
		sel_m = 1'h0;
		schk(1'h0);
		eclr();
		cyc(2);
		chk(32'(fault_n), 32'h1);
		// supply faults drive the alert pin low for their whole length
		lockout <= 1'h1;
		cyc(5);
		chk(32'(alert_wire), 32'h0);
		cyc(40);
		chk(32'(alert_wire), 32'h0);
		lockout <= 1'h0;
		dig_ok <= 1'h0;
		cyc(5);
		chk(32'(alert_wire), 32'h0);
		dig_ok <= 1'h1;
		cyc(5);
		chk(32'(alert_wire), 32'h1);
		print_verdict();
	end

	// hang guard, well above the roughly 4000 cycles the sequence needs
	initial begin
		cyc(20000);
		mismatches++;
		print_verdict();
	end
endmodule
